// File: rtl/hfe_frame_engine.v
/*
 * Bit-oriented frame engine: flag framing, zero stuffing, CRC-CCITT,
 * address filtering and abort handling on one serial transmit and one
 * serial receive line.
 * Assumes rx_line is valid when rx_bit_stb pulses, BIT_DIV of at least 2,
 * and static configuration inputs while frames are in flight.
 */
`timescale 1ns/1ps
`include "hfe_defs.vh"

module hfe_frame_engine #(
    parameter BIT_DIV = `HFE_BIT_DIV,
    parameter FIFO_DEPTH = `HFE_FIFO_DEPTH,
    parameter FIFO_AW = `HFE_FIFO_AW
) (
    input wire clk_sys,
    input wire rst,
    input wire cfg_secondary,
    input wire cfg_ext_addr,
    input wire [7:0] cfg_addr0,
    input wire [7:0] cfg_addr1,
    input wire cfg_idle_flags,
    input wire cfg_rx_en,
    input wire [3:0] cfg_char_bits,
    input wire tx_valid,
    input wire [7:0] tx_data,
    input wire tx_last,
    input wire tx_abort,
    output wire tx_ready,
    output reg tx_line_ff,
    output reg tx_busy_ff,
    input wire rx_line,
    input wire rx_bit_stb,
    output reg [7:0] rx_data_ff,
    output reg rx_valid_ff,
    output reg rx_last_ff,
    output reg rx_err_crc_ff,
    output reg rx_err_frag_ff,
    output reg rx_abort_ff
);

localparam [5:0] TX_IDLE = 6'h01;
localparam [5:0] TX_OPEN = 6'h02;
localparam [5:0] TX_DATA = 6'h04;
localparam [5:0] TX_FCS = 6'h08;
localparam [5:0] TX_CLOSE = 6'h10;
localparam [5:0] TX_ABORT = 6'h20;
localparam [15:0] DIV_LAST = BIT_DIV - 1;

function [15:0] crc_step;
    input [15:0] crc;
    input b;
    begin
        crc_step = {1'b0, crc[15:1]};
        if (crc[0] ^ b) begin
            crc_step = crc_step ^ `HFE_CRC_POLY;
        end
    end
endfunction

// Other sizes are taken as given; out-of-range codes fall back to eight.
wire [3:0] csz = (cfg_char_bits == 4'h0 || cfg_char_bits > `HFE_CHAR_MAX) ?
    `HFE_CHAR_MAX : cfg_char_bits;

////////////////////////////////////////////////////////////////////////////////
// Transmit buffer and bit-rate divider.

wire f_valid;
wire [9:0] f_data;
reg f_pop;
reg [15:0] div_ff;
reg bit_en_ff;

hfe_fifo #(
    .W(10),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
) u_tx_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .s_valid(tx_valid),
    .s_data({tx_abort, tx_last, tx_data}),
    .s_ready(tx_ready),
    .m_valid(f_valid),
    .m_data(f_data),
    .m_ready(f_pop)
);

always @(posedge clk_sys) begin
    if (rst) begin
        div_ff <= 16'h0000;
        bit_en_ff <= 1'b0;
    end else begin
        div_ff <= (div_ff == DIV_LAST) ? 16'h0000 : div_ff + 16'h0001;
        bit_en_ff <= (div_ff == DIV_LAST);
    end
end

////////////////////////////////////////////////////////////////////////////////
// Transmitter.

reg [5:0] tx_st_ff;
reg [15:0] tx_sh_ff;
reg [4:0] tx_cnt_ff;
reg tx_stf_ff;
reg [2:0] tx_ones_ff;
reg [15:0] tx_crc_ff;
reg tx_crcen_ff;
reg tx_lastb_ff;
reg [5:0] nxt_st;
reg [15:0] nxt_sh;
reg [4:0] nxt_cnt;
reg nxt_stf;
reg [2:0] nxt_ones;
reg [15:0] nxt_crc;
reg nxt_crcen;
reg nxt_line;
reg nxt_lastb;

wire stuff_due = tx_stf_ff && (tx_ones_ff == `HFE_STUFF_RUN);
wire [7:0] idle_pat = cfg_idle_flags ? `HFE_FLAG : `HFE_MARK;

// Words are loaded in a cycle without a bit strobe, so loading never
// costs a bit slot on the line.
always @* begin
    nxt_st = tx_st_ff;
    nxt_sh = tx_sh_ff;
    nxt_cnt = tx_cnt_ff;
    nxt_stf = tx_stf_ff;
    nxt_ones = tx_ones_ff;
    nxt_crc = tx_crc_ff;
    nxt_crcen = tx_crcen_ff;
    nxt_line = tx_line_ff;
    nxt_lastb = tx_lastb_ff;
    f_pop = 1'b0;
    if (bit_en_ff) begin
        if (stuff_due) begin
            nxt_line = 1'b0;
            nxt_ones = 3'h0;
        end else if (tx_cnt_ff != 5'h00) begin
            nxt_line = tx_sh_ff[0];
            nxt_sh = {1'b1, tx_sh_ff[15:1]};
            nxt_cnt = tx_cnt_ff - 5'h01;
            nxt_ones = (tx_stf_ff && tx_sh_ff[0]) ? tx_ones_ff + 3'h1 : 3'h0;
            if (tx_crcen_ff) begin
                nxt_crc = crc_step(tx_crc_ff, tx_sh_ff[0]);
            end
        end
    end else if (tx_cnt_ff == 5'h00 && !stuff_due) begin
        // A pending stuffed zero goes out first, or it is lost before the flag.
        nxt_stf = 1'b0;
        nxt_crcen = 1'b0;
        nxt_ones = 3'h0;
        nxt_cnt = 5'h08;
        nxt_sh = {8'h00, idle_pat};
        case (tx_st_ff)
            TX_IDLE, TX_ABORT: begin
                nxt_st = TX_IDLE;
                if (f_valid) begin
                    f_pop = f_data[9];
                    if (!f_data[9]) begin
                        nxt_st = TX_OPEN;
                        nxt_sh = {8'h00, `HFE_FLAG};
                        nxt_crc = `HFE_CRC_INIT;
                    end
                end
            end
            TX_FCS: begin
                nxt_st = TX_CLOSE;
                nxt_sh = {8'h00, `HFE_FLAG};
            end
            TX_OPEN, TX_CLOSE, TX_DATA: begin
                if (tx_st_ff == TX_DATA && tx_lastb_ff) begin
                    nxt_st = TX_FCS;
                    nxt_sh = ~tx_crc_ff;
                    nxt_cnt = `HFE_FCS_BITS;
                    nxt_stf = 1'b1;
                    nxt_ones = tx_ones_ff;
                end else if (f_valid) begin
                    f_pop = 1'b1;
                    if (f_data[9]) begin
                        nxt_st = TX_ABORT;
                        nxt_sh = {8'h00, `HFE_ABORT_PAT};
                    end else begin
                        nxt_st = TX_DATA;
                        nxt_sh = {8'h00, f_data[7:0]};
                        nxt_cnt = {1'b0, csz};
                        nxt_stf = 1'b1;
                        nxt_crcen = 1'b1;
                        nxt_ones = tx_ones_ff;
                        nxt_lastb = f_data[8];
                        if (tx_st_ff == TX_CLOSE) begin
                            nxt_crc = `HFE_CRC_INIT;
                        end
                    end
                end else if (tx_st_ff == TX_OPEN) begin
                    nxt_sh = {8'h00, `HFE_FLAG};
                end else if (tx_st_ff == TX_CLOSE) begin
                    nxt_st = TX_IDLE;
                end else begin
                    // Underrun inside a frame cannot be recovered; abort it.
                    nxt_st = TX_ABORT;
                    nxt_sh = {8'h00, `HFE_ABORT_PAT};
                end
            end
            default: begin
                nxt_st = TX_IDLE;
            end
        endcase
    end
end

always @(posedge clk_sys) begin
    if (rst) begin
        tx_st_ff <= TX_IDLE;
        tx_sh_ff <= 16'h0000;
        tx_cnt_ff <= 5'h00;
        tx_stf_ff <= 1'b0;
        tx_ones_ff <= 3'h0;
        tx_crc_ff <= `HFE_CRC_INIT;
        tx_crcen_ff <= 1'b0;
        tx_lastb_ff <= 1'b0;
        tx_line_ff <= 1'b1;
        tx_busy_ff <= 1'b0;
    end else begin
        tx_st_ff <= nxt_st;
        tx_sh_ff <= nxt_sh;
        tx_cnt_ff <= nxt_cnt;
        tx_stf_ff <= nxt_stf;
        tx_ones_ff <= nxt_ones;
        tx_crc_ff <= nxt_crc;
        tx_crcen_ff <= nxt_crcen;
        tx_lastb_ff <= nxt_lastb;
        tx_line_ff <= nxt_line;
        tx_busy_ff <= (nxt_st != TX_IDLE);
    end
end

////////////////////////////////////////////////////////////////////////////////
// Receiver.

reg [2:0] rx_ones_ff;
reg rx_inf_ff;
reg [5:0] rx_dq_ff;
reg [2:0] rx_dqn_ff;
reg [7:0] rx_as_ff;
reg [3:0] rx_an_ff;
reg [15:0] rx_crc_ff;
reg [7:0] rx_hold_ff;
reg rx_hv_ff;
reg [1:0] rx_idx_ff;
reg rx_aok_ff;
reg rx_adone_ff;
reg rx_sent_ff;
reg [2:0] nxt_r_ones;
reg nxt_inf;
reg [5:0] nxt_dq;
reg [2:0] nxt_dqn;
reg [7:0] nxt_as;
reg [3:0] nxt_an;
reg [15:0] nxt_rcrc;
reg [7:0] nxt_hold;
reg nxt_hv;
reg [1:0] nxt_idx;
reg nxt_aok;
reg nxt_adone;
reg nxt_sent;
reg [7:0] nxt_rdata;
reg nxt_rvalid;
reg nxt_rlast;
reg nxt_ecrc;
reg nxt_efrag;
reg nxt_rabort;
reg dbit;

// Data bits pass a six-bit delay so that the zero and five ones that
// open a flag are dropped before they reach the character assembler.
always @* begin
    nxt_r_ones = rx_ones_ff;
    nxt_inf = rx_inf_ff;
    nxt_dq = rx_dq_ff;
    nxt_dqn = rx_dqn_ff;
    nxt_as = rx_as_ff;
    nxt_an = rx_an_ff;
    nxt_rcrc = rx_crc_ff;
    nxt_hold = rx_hold_ff;
    nxt_hv = rx_hv_ff;
    nxt_idx = rx_idx_ff;
    nxt_aok = rx_aok_ff;
    nxt_adone = rx_adone_ff;
    nxt_sent = rx_sent_ff;
    nxt_rdata = rx_data_ff;
    nxt_rvalid = 1'b0;
    nxt_rlast = 1'b0;
    nxt_ecrc = 1'b0;
    nxt_efrag = 1'b0;
    nxt_rabort = 1'b0;
    dbit = 1'b0;
    if (!cfg_rx_en) begin
        nxt_inf = 1'b0;
        nxt_r_ones = 3'h0;
        nxt_hv = 1'b0;
        nxt_sent = 1'b0;
    end else if (rx_bit_stb) begin
        if (rx_line) begin
            if (rx_ones_ff == `HFE_FLAG_RUN) begin
                nxt_r_ones = `HFE_ABORT_RUN;
                nxt_rabort = rx_inf_ff && rx_sent_ff;
                nxt_inf = 1'b0;
                nxt_hv = 1'b0;
                nxt_sent = 1'b0;
            end else if (rx_ones_ff != `HFE_ABORT_RUN) begin
                nxt_r_ones = rx_ones_ff + 3'h1;
                dbit = (rx_ones_ff < `HFE_STUFF_RUN);
            end
        end else begin
            nxt_r_ones = 3'h0;
            dbit = (rx_ones_ff < `HFE_STUFF_RUN);
            if (rx_ones_ff == `HFE_FLAG_RUN) begin
                if (rx_inf_ff && rx_hv_ff && rx_aok_ff && rx_adone_ff) begin
                    nxt_rdata = rx_hold_ff;
                    nxt_rvalid = 1'b1;
                    nxt_rlast = 1'b1;
                    nxt_ecrc = (rx_crc_ff != `HFE_CRC_GOOD);
                    nxt_efrag = (rx_an_ff != 4'h0) ||
                        (rx_idx_ff != `HFE_MIN_BYTES);
                end
                nxt_inf = 1'b1;
                nxt_dqn = 3'h0;
                nxt_as = 8'h00;
                nxt_an = 4'h0;
                nxt_rcrc = `HFE_CRC_INIT;
                nxt_hv = 1'b0;
                nxt_idx = 2'h0;
                nxt_aok = 1'b0;
                nxt_adone = 1'b0;
                nxt_sent = 1'b0;
            end
        end
        if (dbit && rx_inf_ff) begin
            nxt_dq = {rx_line, rx_dq_ff[5:1]};
            if (rx_dqn_ff != `HFE_DLY_BITS) begin
                nxt_dqn = rx_dqn_ff + 3'h1;
            end else begin
                nxt_rcrc = crc_step(rx_crc_ff, rx_dq_ff[0]);
                nxt_as[rx_an_ff[2:0]] = rx_dq_ff[0];
                nxt_an = rx_an_ff + 4'h1;
                if (nxt_an == csz) begin
                    nxt_an = 4'h0;
                    nxt_as = 8'h00;
                    nxt_hold = rx_as_ff;
                    nxt_hold[rx_an_ff[2:0]] = rx_dq_ff[0];
                    nxt_hv = 1'b1;
                    if (rx_idx_ff != `HFE_MIN_BYTES) begin
                        nxt_idx = rx_idx_ff + 2'h1;
                    end
                    if (rx_idx_ff == 2'h0) begin
                        nxt_adone = !cfg_secondary || !cfg_ext_addr ||
                            nxt_hold[0];
                        nxt_aok = !cfg_secondary || (nxt_hold == cfg_addr0) ||
                            (nxt_hold == `HFE_BCAST);
                    end else if (!rx_adone_ff) begin
                        nxt_adone = 1'b1;
                        nxt_aok = rx_aok_ff && (nxt_hold == cfg_addr1);
                    end
                    if (rx_hv_ff && nxt_aok && nxt_adone) begin
                        nxt_rdata = rx_hold_ff;
                        nxt_rvalid = 1'b1;
                        nxt_sent = 1'b1;
                    end
                end
            end
        end
    end
end

always @(posedge clk_sys) begin
    if (rst) begin
        rx_ones_ff <= 3'h0;
        rx_inf_ff <= 1'b0;
        rx_dq_ff <= 6'h00;
        rx_dqn_ff <= 3'h0;
        rx_as_ff <= 8'h00;
        rx_an_ff <= 4'h0;
        rx_crc_ff <= `HFE_CRC_INIT;
        rx_hold_ff <= 8'h00;
        rx_hv_ff <= 1'b0;
        rx_idx_ff <= 2'h0;
        rx_aok_ff <= 1'b0;
        rx_adone_ff <= 1'b0;
        rx_sent_ff <= 1'b0;
        rx_data_ff <= 8'h00;
        rx_valid_ff <= 1'b0;
        rx_last_ff <= 1'b0;
        rx_err_crc_ff <= 1'b0;
        rx_err_frag_ff <= 1'b0;
        rx_abort_ff <= 1'b0;
    end else begin
        rx_ones_ff <= nxt_r_ones;
        rx_inf_ff <= nxt_inf;
        rx_dq_ff <= nxt_dq;
        rx_dqn_ff <= nxt_dqn;
        rx_as_ff <= nxt_as;
        rx_an_ff <= nxt_an;
        rx_crc_ff <= nxt_rcrc;
        rx_hold_ff <= nxt_hold;
        rx_hv_ff <= nxt_hv;
        rx_idx_ff <= nxt_idx;
        rx_aok_ff <= nxt_aok;
        rx_adone_ff <= nxt_adone;
        rx_sent_ff <= nxt_sent;
        rx_data_ff <= nxt_rdata;
        rx_valid_ff <= nxt_rvalid;
        rx_last_ff <= nxt_rlast;
        rx_err_crc_ff <= nxt_ecrc;
        rx_err_frag_ff <= nxt_efrag;
        rx_abort_ff <= nxt_rabort;
    end
end

endmodule

// File: include/hfe_defs.vh
/*
 * Constants of the bit-oriented frame engine: line patterns, bit runs,
 * block check values and default sizes.
 * Assumes it is included by bare name from the design files.
 */
`ifndef HFE_DEFS_VH
`define HFE_DEFS_VH

`define HFE_FLAG 8'h7e
`define HFE_MARK 8'hff
`define HFE_ABORT_PAT 8'hff
`define HFE_BCAST 8'hff
`define HFE_STUFF_RUN 3'h5
`define HFE_FLAG_RUN 3'h6
`define HFE_ABORT_RUN 3'h7
`define HFE_DLY_BITS 3'h6
`define HFE_CHAR_MAX 4'h8
`define HFE_FCS_BITS 5'h10
`define HFE_MIN_BYTES 2'h3
`define HFE_CRC_INIT 16'hffff
`define HFE_CRC_POLY 16'h8408
`define HFE_CRC_GOOD 16'hf0b8
`define HFE_BIT_DIV 4
`define HFE_FIFO_DEPTH 4
`define HFE_FIFO_AW 2

`endif

// File: rtl/hfe_fifo.v
/*
 * Small first-in first-out buffer with valid and ready on both sides.
 * Assumes a power-of-two depth and one clock with synchronous reset.
 */
`timescale 1ns/1ps

module hfe_fifo #(
    parameter W = 10,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk_sys,
    input wire rst,
    input wire s_valid,
    input wire [W-1:0] s_data,
    output wire s_ready,
    output wire m_valid,
    output wire [W-1:0] m_data,
    input wire m_ready
);

localparam [AW:0] FULL = DEPTH;

reg [W-1:0] mem_ff [0:DEPTH-1];
reg [AW-1:0] wp_ff;
reg [AW-1:0] rp_ff;
reg [AW:0] cnt_ff;
reg rdy_ff;
reg [AW:0] nxt_cnt;
wire push;
wire pop;

// Ready is registered so the engine's ready port comes from a flip-flop.
assign s_ready = rdy_ff;
assign m_valid = (cnt_ff != {(AW+1){1'b0}});
assign m_data = mem_ff[rp_ff];
assign push = s_valid && rdy_ff;
assign pop = m_valid && m_ready;

always @* begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
        nxt_cnt = cnt_ff + {{AW{1'b0}}, 1'b1};
    end else if (pop && !push) begin
        nxt_cnt = cnt_ff - {{AW{1'b0}}, 1'b1};
    end
end

always @(posedge clk_sys) begin
    if (push) begin
        mem_ff[wp_ff] <= s_data;
    end
end

always @(posedge clk_sys) begin
    if (rst) begin
        wp_ff <= {AW{1'b0}};
        rp_ff <= {AW{1'b0}};
        cnt_ff <= {(AW+1){1'b0}};
        rdy_ff <= 1'b0;
    end else begin
        if (push) begin
            wp_ff <= wp_ff + {{(AW-1){1'b0}}, 1'b1};
        end
        if (pop) begin
            rp_ff <= rp_ff + {{(AW-1){1'b0}}, 1'b1};
        end
        cnt_ff <= nxt_cnt;
        rdy_ff <= (nxt_cnt != FULL);
    end
end

endmodule

// File: sim/hfe_asserts.sv
/* Port checker for the frame engine.
   Assumes BIT_DIV of 4 and is bound into every hfe_frame_engine. */
`timescale 1ns/1ps
module hfe_asserts (
    input wire clk_sys,
    input wire rst,
    input wire cfg_idle_flags,
    input wire cfg_rx_en,
    input wire tx_ready,
    input wire tx_line_ff,
    input wire tx_busy_ff,
    input wire rx_bit_stb,
    input wire rx_valid_ff,
    input wire rx_last_ff,
    input wire rx_err_crc_ff,
    input wire rx_err_frag_ff,
    input wire rx_abort_ff
);
    // Idle with marks; a flag already on the line may need 36 clocks to finish.
    reg [5:0] mark_cnt_ff;
    always @(posedge clk_sys) begin
        if (rst || tx_busy_ff || cfg_idle_flags)
            mark_cnt_ff <= 6'h00;
        else if (mark_cnt_ff != 6'h3f)
            mark_cnt_ff <= mark_cnt_ff + 6'h01;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    a_idle_mark_line: assert property (mark_cnt_ff > 6'h28 |-> tx_line_ff)
        else $error("tx line not high while idle");
    a_bit_hold_time: assert property ($changed(tx_line_ff) |=> $stable(tx_line_ff) [*3])
        else $error("tx bit shorter than four clocks");
    a_open_flag_zero: assert property ($rose(tx_busy_ff) |-> ##[0:48] !tx_line_ff)
        else $error("no opening flag after start");
    a_rx_after_strobe: assert property (rx_valid_ff |-> $past(rx_bit_stb))
        else $error("delivery without a bit strobe");
    a_last_with_valid: assert property (rx_last_ff |-> rx_valid_ff)
        else $error("frame end without a character");
    a_err_at_end: assert property ((rx_err_crc_ff || rx_err_frag_ff) |-> rx_last_ff)
        else $error("error flag away from frame end");
    a_abort_no_end: assert property (rx_abort_ff |-> !rx_last_ff)
        else $error("aborted frame reported as ended");
    a_rx_off_quiet: assert property (!cfg_rx_en ##1 !cfg_rx_en |-> !rx_valid_ff && !rx_abort_ff)
        else $error("receiver output while disabled");
    a_ready_release: assert property ($fell(rst) |-> !tx_ready ##1 tx_ready)
        else $error("tx ready wrong after reset");
    c_frame_good: cover property (rx_last_ff && !rx_err_crc_ff);
    c_frame_bad: cover property (rx_err_crc_ff);
    c_frame_abort: cover property (rx_abort_ff);
    c_fifo_full: cover property (!tx_ready);
endmodule
bind hfe_frame_engine hfe_asserts hfe_asserts_inst (.clk_sys, .rst, .cfg_idle_flags,
    .cfg_rx_en, .tx_ready, .tx_line_ff, .tx_busy_ff, .rx_bit_stb, .rx_valid_ff,
    .rx_last_ff, .rx_err_crc_ff, .rx_err_frag_ff, .rx_abort_ff);

// File: sim/hfe_remote_station.sv
/* Remote station model: sends stuffed frames with bit strobes, decodes the tx line.
   Assumes BIT_DIV of 4 and a bit phase that restarts with reset. */
`timescale 1ns/1ps
module hfe_remote_station (
    input wire clk_sys,
    input wire rst,
    input wire tx_line_ff,
    output logic rx_line,
    output logic rx_bit_stb
);
    logic [7:0] sq[$];
    logic [7:0] rq[$];
    logic dq[$];
    logic [7:0] b;
    logic [1:0] ph_ff;
    logic busy = 1'b0;
    integer nfr = 0, nab = 0, ones = 0, run = 0, i, j;
    initial begin
        rx_line = 1'b1;
        rx_bit_stb = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    function automatic [15:0] crc_upd(input [15:0] c, input [7:0] d);
        integer k;
        for (k = 0; k < 8; k++)
            c = (c[0] ^ d[k]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
        return c;
    endfunction
    task automatic sbit(input logic v);
        @(posedge clk_sys);
        rx_line <= v;
        rx_bit_stb <= 1'b1;
        @(posedge clk_sys);
        rx_bit_stb <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    // Zero after five ones; the run carries across byte borders.
    task automatic sbyte(input [7:0] d, input logic raw);
        integer k;
        for (k = 0; k < 8; k++) begin
            sbit(d[k]);
            run = (d[k] && !raw) ? run + 1 : 0;
            if (run == 5) begin
                sbit(1'b0);
                run = 0;
            end
        end
    endtask
    // Frame with optional opening flag, so two frames can share one.
    task automatic send(input logic op, input logic ab, input logic bad);
        logic [15:0] c;
        integer k;
        c = 16'hffff;
        busy = 1'b1;
        run = 0;
        if (op)
            sbyte(8'h7e, 1'b1);
        for (k = 0; k < sq.size(); k++) begin
            sbyte(sq[k], 1'b0);
            c = crc_upd(c, sq[k]);
        end
        c = ~c ^ {15'h0000, bad};
        if (ab)
            sbyte(8'hff, 1'b1);
        else begin
            sbyte(c[7:0], 1'b0);
            sbyte(c[15:8], 1'b0);
            sbyte(8'h7e, 1'b1);
        end
        busy = 1'b0;
    endtask
    // Strobe stands still between frames, so the data line toggles to expose stale sampling.
    // Decoder drops stuffed zeros, ends frames at flags and counts aborts.
    always @(posedge clk_sys) begin
        if (!busy)
            rx_line <= ~rx_line;
        ph_ff <= rst ? 2'h0 : ph_ff + 2'h1;
        if (!rst && ph_ff == 2'h2) begin
            if (tx_line_ff === 1'b1) begin
                ones = ones + 1;
                dq.push_back(1'b1);
                if (ones >= 7) begin
                    if (dq.size() > 13)
                        nab = nab + 1;
                    dq.delete();
                end
            end else begin
                if (ones == 6) begin
                    // Under fifteen bits is a flag pair or start-up junk, not a frame.
                    if (dq.size() >= 15) begin
                        for (i = 0; i + 15 <= dq.size(); i = i + 8) begin
                            for (j = 0; j < 8; j++)
                                b[j] = dq[i + j];
                            rq.push_back(b);
                        end
                        nfr = nfr + 1;
                    end
                    dq.delete();
                end else if (ones != 5)
                    dq.push_back(1'b0);
                ones = 0;
            end
        end
    end
endmodule

// File: sim/hfe_frame_engine_test.sv
/* Self-checking bench for the frame engine against the remote station model.
   Assumes a 10 MHz clock and BIT_DIV of 4 in design, model and checker. */
`timescale 1ns/1ps
module hfe_frame_engine_test;
    logic clk_sys = 1'b0, rst = 1'b1, cfg_secondary = 1'b0, cfg_ext_addr = 1'b0;
    logic cfg_idle_flags = 1'b1, cfg_rx_en = 1'b0, tx_valid = 1'b0, tx_last = 1'b0;
    logic tx_abort = 1'b0, full_seen;
    logic [7:0] cfg_addr0 = 8'h5a, cfg_addr1 = 8'h77, tx_data = 8'h00;
    logic [3:0] cfg_char_bits = 4'h8;
    wire tx_ready, tx_line_ff, tx_busy_ff, rx_line, rx_bit_stb, rx_valid_ff, rx_last_ff;
    wire rx_err_crc_ff, rx_err_frag_ff, rx_abort_ff;
    wire [7:0] rx_data_ff;
    logic [7:0] rxq[$];
    integer n_fail = 0, check_count = 0, n_last = 0, n_crc = 0, n_rab = 0, n_frag = 0, k;
    always #50 clk_sys = ~clk_sys;
    hfe_frame_engine #(.BIT_DIV(4), .FIFO_DEPTH(4), .FIFO_AW(2)) hfe_frame_engine_inst (
        .clk_sys, .rst, .cfg_secondary, .cfg_ext_addr, .cfg_addr0, .cfg_addr1,
        .cfg_idle_flags, .cfg_rx_en, .cfg_char_bits, .tx_valid, .tx_data, .tx_last,
        .tx_abort, .tx_ready, .tx_line_ff, .tx_busy_ff, .rx_line, .rx_bit_stb, .rx_data_ff,
        .rx_valid_ff, .rx_last_ff, .rx_err_crc_ff, .rx_err_frag_ff, .rx_abort_ff);
    hfe_remote_station hfe_remote_station_inst (.clk_sys, .rst, .tx_line_ff, .rx_line,
        .rx_bit_stb);
    always @(posedge clk_sys) begin
        if (rx_valid_ff === 1'b1)
            rxq.push_back(rx_data_ff);
        n_last = n_last + (rx_last_ff === 1'b1);
        n_crc = n_crc + (rx_err_crc_ff === 1'b1);
        n_rab = n_rab + (rx_abort_ff === 1'b1);
        n_frag = n_frag + (rx_err_frag_ff === 1'b1);
    end
    ////////////////////////////////////////////////////////////
    task check(input string what, input logic [15:0] seen, input logic [15:0] want);
        check_count = check_count + 1;
        if (seen !== want) begin
            n_fail = n_fail + 1;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task stop_hang;
        n_fail = n_fail + 1;
        print_verdict;
    endtask
    // Holds the word until the edge that takes it; the caller drops valid.
    task push(input logic [7:0] d, input logic l, input logic a);
        tx_valid <= 1'b1;
        tx_data <= d;
        tx_last <= l;
        tx_abort <= a;
        k = 0;
        @(posedge clk_sys);
        while (tx_ready !== 1'b1 && k < 500) begin
            full_seen = 1'b1;
            k = k + 1;
            @(posedge clk_sys);
        end
        if (k >= 500)
            stop_hang;
    endtask
    task wait_tx(input integer nf, input integer na);
        k = 0;
        while ((hfe_remote_station_inst.nfr < nf || hfe_remote_station_inst.nab < na)
            && k < 4000) begin
            k = k + 1;
            @(posedge clk_sys);
        end
        if (k >= 4000)
            stop_hang;
    endtask
    task rx_send(input logic [7:0] a, input logic [7:0] c, input logic op, input logic ab,
        input logic bad);
        hfe_remote_station_inst.sq = '{a, c, 8'h7e, 8'h81};
        hfe_remote_station_inst.send(op, ab, bad);
    endtask
    ////////////////////////////////////////////////////////////
    task t_tx_frame;
        logic [7:0] want[6];
        logic [15:0] c;
        integer i;
        want = '{8'h3e, 8'hf8, 8'h7e, 8'hff, 8'h01, 8'h00};
        full_seen = 1'b0;
        for (i = 0; i < 6; i++)
            push(want[i], i == 5, 1'b0);
        tx_valid <= 1'b0;
        wait_tx(1, 0);
        check("tx fifo full", full_seen, 1'b1);
        check("tx byte count", hfe_remote_station_inst.rq.size(), 8);
        c = 16'hffff;
        for (i = 0; i < 8; i++) begin
            if (i < 6)
                check("tx byte", hfe_remote_station_inst.rq[i], want[i]);
            c = hfe_remote_station_inst.crc_upd(c, hfe_remote_station_inst.rq[i]);
        end
        check("tx check residue", c, 16'hf0b8);
        check("tx false aborts", hfe_remote_station_inst.nab, 0);
        check("tx ready drained", tx_ready, 1'b1);
    endtask
    task t_tx_abort;
        cfg_idle_flags <= 1'b0;
        push(8'h55, 1'b0, 1'b0);
        push(8'h00, 1'b0, 1'b1);
        tx_valid <= 1'b0;
        wait_tx(1, 1);
        check("tx abort sent", hfe_remote_station_inst.nab, 1);
        check("tx frames", hfe_remote_station_inst.nfr, 1);
    endtask
    task t_rx_primary;
        rxq.delete();
        n_last = 0;
        rx_send(8'h33, 8'h03, 1'b1, 1'b0, 1'b0);
        check("rx count", rxq.size(), 6);
        check("rx addr", rxq[0], 8'h33);
        check("rx flag byte", rxq[2], 8'h7e);
        check("rx ends", n_last, 1);
        check("rx crc errors", n_crc, 0);
    endtask
    task t_rx_secondary;
        cfg_secondary <= 1'b1;
        rxq.delete();
        n_last = 0;
        rx_send(8'h33, 8'h01, 1'b1, 1'b0, 1'b0);
        rx_send(8'hff, 8'h02, 1'b1, 1'b0, 1'b0);
        rx_send(8'h5a, 8'h03, 1'b0, 1'b0, 1'b1);
        check("rx filtered count", rxq.size(), 12);
        check("rx broadcast", rxq[0], 8'hff);
        check("rx shared flag", rxq[6], 8'h5a);
        check("rx frame ends", n_last, 2);
        check("rx crc errors", n_crc, 1);
        check("rx frag errors", n_frag, 0);
    endtask
    task t_rx_abort;
        cfg_secondary <= 1'b0;
        n_last = 0;
        rx_send(8'h5a, 8'h04, 1'b1, 1'b1, 1'b0);
        check("rx abort pulse", n_rab, 1);
        check("rx no end", n_last, 0);
        cfg_char_bits <= 4'h7;
        rxq.delete();
        rx_send(8'h5a, 8'h04, 1'b1, 1'b0, 1'b0);
        check("rx odd size count", rxq.size(), 6);
        check("rx odd size addr", rxq[0], 8'h5a);
        check("rx partial char", n_frag, 1);
        cfg_char_bits <= 4'h8;
    endtask
    task t_rx_ext;
        cfg_secondary <= 1'b1;
        cfg_ext_addr <= 1'b1;
        rxq.delete();
        n_last = 0;
        rx_send(8'h5a, 8'h77, 1'b1, 1'b0, 1'b0);
        rx_send(8'h5a, 8'h78, 1'b1, 1'b0, 1'b0);
        check("rx ext count", rxq.size(), 6);
        check("rx ext second", rxq[1], 8'h77);
        check("rx ext ends", n_last, 1);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check("tx line idle", tx_line_ff, 1'b1);
        check("tx busy idle", tx_busy_ff, 1'b0);
        cfg_rx_en <= 1'b1;
        t_tx_frame;
        t_tx_abort;
        t_rx_primary;
        t_rx_secondary;
        t_rx_abort;
        t_rx_ext;
        print_verdict;
    end
endmodule
